// *** inc/ext_bus_defs.vh ***
// Constants for the external bus hold and chip-select block.
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define NUM_CS 6
`define ADDR_W 24
`define CS0_RESET_BASE 24'hff2000
`define CS0_RESET_TOP 24'hff20ff
`define CS_DEFAULT_IDX 3'h5
`define HOLD_EN_BIT 7
`define PIN3_BIT 3
`define SYNC_IDLE 3'h7
`define WIN_SEL_RESET 8'h00
`define PORT_CFG_RESET 8'h00
`define CS_EMPTY_BASE 24'hffffff
`define CS_EMPTY_TOP 24'h000000
`define ST_BUS 2'h0
`define ST_FINISH 2'h1
`define ST_HELD 2'h2
`endif

// *** logic/ext_bus_hold_cs.v ***
// External bus hold handshake, chip-select decode and half-rate clock output.
// Functional notes
// - Bus request low while held with cycle pending.
// - Hold enable forces shared pin to request.
// - Pin configuration writes ignored while enabled.
// - Bus request never before hold acknowledge.
// - Bus request held until hold request released.
// - Clock out at half rate, even duty.
// - Chip select asserts for address in range.
// - Remap also selects on next range.
// - Unmatched address: no select, config five.
// - Chip select zero covers reset range.
// - Hold acknowledge low once bus released.
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module ext_bus_hold_cs #(
  parameter NCS = `NUM_CS,
  parameter AW = `ADDR_W
) (
  // Clock and reset.
  input wire mclk_i,
  input wire rst_i,
  // Hold protocol pins.
  input wire hold_req_n_i,
  output reg hold_ack_n_o,
  output reg bus_request_n_o,
  output reg bus_float_o,
  // Window select register write and shared port configuration.
  input wire win_sel_we_i,
  input wire [7:0] win_sel_wdata_i,
  output reg [7:0] window_select_reg_o,
  input wire port_cfg_we_i,
  input wire [7:0] port_cfg_wdata_i,
  output reg [7:0] port2_cfg_o,
  output reg port2_pin3_o,
  // Bus controller cycle interface.
  input wire cycle_pending_i,
  input wire cycle_active_i,
  input wire [AW-1:0] cycle_addr_i,
  // Chip-select range programming.
  input wire cs_we_i,
  input wire [2:0] cs_idx_i,
  input wire [AW-1:0] cs_base_i,
  input wire [AW-1:0] cs_top_i,
  input wire remap_en_i,
  // Chip-select and clock outputs.
  output reg [NCS-1:0] chip_select_n_o,
  output reg [2:0] bus_cfg_sel_o,
  output reg half_rate_clock_out_o
);
  reg [2:0] hold_sync_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  wire [NCS-1:0] hit;
  reg [NCS-1:0] sel;
  reg [2:0] cfg;
  reg hold_req;
  integer i;
  wire hold_en = window_select_reg_o[`HOLD_EN_BIT];
  // ----------------------------------------
  // Hold request synchroniser.
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      hold_sync_reg <= `SYNC_IDLE;
      hold_req <= 1'b0;
    end else begin
      hold_sync_reg <= {hold_sync_reg[1:0], hold_req_n_i};
      if (hold_sync_reg[1] == hold_sync_reg[2]) begin
        hold_req <= ~hold_sync_reg[2];
      end
    end
  end
  // ----------------------------------------
  // Hold handshake state machine.
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_BUS: begin
        if (hold_en && hold_req) begin
          state_next = `ST_FINISH;
        end
      end
      `ST_FINISH: begin
        if (!cycle_active_i) begin
          state_next = `ST_HELD;
        end
      end
      `ST_HELD: begin
        if (!hold_req) begin
          state_next = `ST_BUS;
        end
      end
      default: begin
        state_next = `ST_BUS;
      end
    endcase
  end
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= `ST_BUS;
      hold_ack_n_o <= 1'b1;
      bus_request_n_o <= 1'b1;
      bus_float_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_ack_n_o <= ~(state_next == `ST_HELD);
      bus_float_o <= (state_next == `ST_HELD);
      if (state_next != `ST_HELD) begin
        bus_request_n_o <= 1'b1;
      end else if (cycle_pending_i) begin
        bus_request_n_o <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Window select and shared port pin.
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      window_select_reg_o <= `WIN_SEL_RESET;
      port2_cfg_o <= `PORT_CFG_RESET;
      port2_pin3_o <= 1'b1;
    end else begin
      if (win_sel_we_i) begin
        window_select_reg_o <= win_sel_wdata_i;
      end
      if (port_cfg_we_i && !hold_en) begin
        port2_cfg_o <= port_cfg_wdata_i;
      end
      if (hold_en) begin
        port2_pin3_o <= (state_next == `ST_HELD && cycle_pending_i) ? 1'b0 :
          (state_next == `ST_HELD ? bus_request_n_o : 1'b1);
      end else begin
        port2_pin3_o <= port2_cfg_o[`PIN3_BIT];
      end
    end
  end
  // ----------------------------------------
  // Chip-select ranges and decode.
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCS; g = g + 1) begin : slot
      cs_range_slot #(
        .AW(AW),
        .RST_BASE(g == 0 ? `CS0_RESET_BASE : `CS_EMPTY_BASE),
        .RST_TOP(g == 0 ? `CS0_RESET_TOP : `CS_EMPTY_TOP)
      ) cs_range_slot_i (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .we_i(cs_we_i && ({29'h0, cs_idx_i} == g)),
        .base_i(cs_base_i),
        .top_i(cs_top_i),
        .addr_i(cycle_addr_i),
        .hit_o(hit[g])
      );
    end
  endgenerate
  always @* begin
    cfg = `CS_DEFAULT_IDX;
    sel = hit;
    for (i = 0; i < NCS - 1; i = i + 1) begin
      if (remap_en_i) begin
        sel[i] = hit[i] | hit[i+1];
      end
    end
    for (i = NCS - 1; i >= 0; i = i - 1) begin
      if (hit[i]) begin
        cfg = i[2:0];
      end
    end
  end
  always @(posedge mclk_i) begin
    if (rst_i) begin
      chip_select_n_o <= {NCS{1'b1}};
      bus_cfg_sel_o <= `CS_DEFAULT_IDX;
      half_rate_clock_out_o <= 1'b0;
    end else begin
      chip_select_n_o <= (cycle_active_i && !bus_float_o) ? ~sel : {NCS{1'b1}};
      bus_cfg_sel_o <= cfg;
      half_rate_clock_out_o <= ~half_rate_clock_out_o;
    end
  end
endmodule

// ----------------------------------------
// One chip-select range slot.
// ----------------------------------------
module cs_range_slot #(
  parameter AW = `ADDR_W,
  parameter [AW-1:0] RST_BASE = `CS_EMPTY_BASE,
  parameter [AW-1:0] RST_TOP = `CS_EMPTY_TOP
) (
  // Clock and reset.
  input wire mclk_i,
  input wire rst_i,
  // Range programming.
  input wire we_i,
  input wire [AW-1:0] base_i,
  input wire [AW-1:0] top_i,
  // Address compare.
  input wire [AW-1:0] addr_i,
  output wire hit_o
);
  reg [AW-1:0] base_reg;
  reg [AW-1:0] top_reg;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      base_reg <= RST_BASE;
      top_reg <= RST_TOP;
    end else if (we_i) begin
      base_reg <= base_i;
      top_reg <= top_i;
    end
  end
  assign hit_o = (addr_i >= base_reg) && (addr_i <= top_reg);
endmodule

// *** testbench/ext_bus_props.sv ***
// Checker for the bus hold block.
`timescale 1ns/1ps
module ext_bus_props(input logic mclk_i, rst_i, hold_req_n_i, hold_ack_n_o, bus_request_n_o, bus_float_o,
  port2_pin3_o, half_rate_clock_out_o, cycle_pending_i, input logic [7:0] window_select_reg_o, port2_cfg_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_req_ack: assert property (!bus_request_n_o |-> !hold_ack_n_o) else $error("req");
  a_req_pend: assert property (!hold_ack_n_o && cycle_pending_i && !hold_req_n_i
    |-> ##[1:2] !bus_request_n_o) else $error("pend");
  a_req_held: assert property ($rose(bus_request_n_o) |-> $past(hold_req_n_i, 2)) else $error("drop");
  a_pin_req: assert property (window_select_reg_o[7] && $past(window_select_reg_o[7])
    && $stable(bus_request_n_o) |-> port2_pin3_o == bus_request_n_o) else $error("pin");
  a_cfg_lock: assert property (window_select_reg_o[7] |=> $stable(port2_cfg_o)) else $error("cfg");
  a_clk_half: assert property (half_rate_clock_out_o |=> !half_rate_clock_out_o) else $error("clk");
  a_clk_rise: assert property (!half_rate_clock_out_o |=> half_rate_clock_out_o) else $error("clk low");
  a_ack_float: assert property (!hold_ack_n_o |-> bus_float_o) else $error("float");
  a_ack_hold: assert property ($fell(hold_ack_n_o) |-> !$past(hold_req_n_i, 3)) else $error("ack");
  c_req: cover property (!bus_request_n_o);
  c_ack: cover property ($fell(hold_ack_n_o));
  c_free: cover property ($rose(hold_ack_n_o));
endmodule
bind ext_bus_hold_cs ext_bus_props ext_bus_props_i(.*);

// *** testbench/bus_master_model.sv ***
// Outside bus master that asks for the bus.
`timescale 1ns/1ps
module bus_master_model(input logic want_i, output logic hold_req_n_o = 1'h1);
  logic lclk = 1'h0;
  initial forever #40 lclk = !lclk;
  always @(posedge lclk) hold_req_n_o <= !want_i;
endmodule

// *** testbench/ext_bus_hold_cs_tb.sv ***
// Testbench for the bus hold and chip-select block.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("BAD %s %h %h", n, e, s); end end
module ext_bus_hold_cs_tb;
  logic mclk_i = 0, rst_i = 1, win_sel_we_i = 0, port_cfg_we_i = 0, cycle_pending_i = 0, cycle_active_i = 0;
  logic cs_we_i = 0, remap_en_i = 0, want = 0, clk_seen = 0;
  logic [7:0] win_sel_wdata_i = 0, port_cfg_wdata_i = 0;
  logic [23:0] cycle_addr_i = 0, cs_base_i = 24'h000100, cs_top_i = 24'h0001ff;
  logic [2:0] cs_idx_i = 3'h1;
  wire hold_req_n_i, hold_ack_n_o, bus_request_n_o, bus_float_o, port2_pin3_o, half_rate_clock_out_o;
  wire [7:0] window_select_reg_o, port2_cfg_o;
  wire [5:0] chip_select_n_o;
  wire [2:0] bus_cfg_sel_o;
  int fail_count = 0, n_checks = 0;
  ext_bus_hold_cs ext_bus_hold_cs_i(.*);
  bus_master_model bus_master_model_i(.want_i(want), .hold_req_n_o(hold_req_n_i));
  initial forever #5 mclk_i = !mclk_i;
  task wr(logic w, logic [7:0] d);
    @(posedge mclk_i) {win_sel_we_i, port_cfg_we_i, win_sel_wdata_i, port_cfg_wdata_i} <= {w, !w, d, d};
    @(posedge mclk_i) {win_sel_we_i, port_cfg_we_i} <= 2'h0;
  endtask
  task look(logic [23:0] a, logic r, logic [5:0] e);
    @(posedge mclk_i) {cycle_active_i, cycle_addr_i, remap_en_i} <= {1'h1, a, r};
    repeat (3) @(negedge mclk_i);
    `CHK("cs", e, chip_select_n_o)
  endtask
  task hold(logic w, logic e);
    @(posedge mclk_i) {want, cycle_active_i, cycle_pending_i} <= {w, 1'h0, w};
    for (int i = 0; i < 40 && hold_ack_n_o !== e; i++) @(negedge mclk_i);
    repeat (4) @(negedge mclk_i);
    `CHK("ack", e, hold_ack_n_o)
    `CHK("float", !e, bus_float_o)
    `CHK("req", e, bus_request_n_o)
    `CHK("pin", e, port2_pin3_o)
  endtask
  task close_out;
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    @(negedge mclk_i) `CHK("sel", 3'h5, bus_cfg_sel_o)
    clk_seen = half_rate_clock_out_o;
    @(negedge mclk_i) `CHK("clk", !clk_seen, half_rate_clock_out_o)
    look(24'hff20ff, 0, 6'h3e);
    `CHK("sel", 3'h0, bus_cfg_sel_o)
    look(24'hff2100, 0, 6'h3f);
    `CHK("sel", 3'h5, bus_cfg_sel_o)
    @(posedge mclk_i) cs_we_i <= 1;
    @(posedge mclk_i) cs_we_i <= 0;
    look(24'h000100, 1, 6'h3c);
    `CHK("sel", 3'h1, bus_cfg_sel_o)
    look(24'h0001ff, 0, 6'h3d);
    wr(1, 8'h80);
    @(negedge mclk_i) `CHK("win", 8'h80, window_select_reg_o)
    wr(0, 8'h5a);
    @(posedge mclk_i) want <= 1;
    repeat (30) @(negedge mclk_i);
    `CHK("wait", 1'h1, hold_ack_n_o)
    `CHK("cfg", 8'h00, port2_cfg_o)
    hold(1, 0);
    hold(0, 1);
    wr(1, 8'h00);
    wr(0, 8'h5a);
    @(negedge mclk_i) `CHK("cfg", 8'h5a, port2_cfg_o)
    close_out;
  end
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule
